// ===== core/sfq_fifo_dev.sv
// Synchronous FIFO device end: storage, pointers, flags, offset
// programming, retransmit and depth-cascade tokens.
// Assumes write and read sides share the one clock; the link pins are
// driven by a controller that keeps its own side of the protocol.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sfq_regs.svh"
module sfq_fifo_dev
    import sfq_pkg::*;
#(
    parameter int DEPTH = `SFQ_DEPTH_SMALL,
    parameter int DW = `SFQ_DATA_W,
    parameter int OW = `SFQ_OFFSET_W
) (
    input wire logic clock, // Common write/read clock.
    input wire logic resetn, // Asynchronous reset, active low.
    sfq_link_if.dev link // Pins toward the controller.
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int XW = 16;

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic wrapped;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic wtoken;
    logic rtoken;
    logic [OW-1:0] ae_dist;
    logic [OW-1:0] af_dist;
    logic [OW-1:0] off_rd;

    // ----------------------------------------------------------------
    // Access qualification
    // ----------------------------------------------------------------
    // A reset cycle shuts out every strobe.
    wire rst_cycle = !link.master_reset_n;
    wire ld_mode = !link.offset_load_select_n;
    wire wr_go = !link.wen_n && !rst_cycle;
    wire rd_go = !link.ren_n && !rst_cycle;
    // Retransmit counts only outside depth expansion.
    wire rt_go = link.retransmit_pulse && !link.depth_mode && !rst_cycle;
    // Only the device holding the token takes part in a cascade.
    wire wr_own = !link.depth_mode || wtoken;
    wire rd_own = !link.depth_mode || rtoken;
    // Offset mode diverts strobes away from the pointers.
    wire wr_fifo = wr_go && !ld_mode && !rt_go && link.full_flag_n && wr_own;
    wire rd_fifo = rd_go && !ld_mode && !rt_go && link.empty_flag_n && rd_own;
    wire off_wr = wr_go && ld_mode;
    wire off_rd_go = rd_go && ld_mode;
    wire wr_last = wr_fifo && (wptr == AW'(DEPTH - 1));
    wire rd_last = rd_fifo && (rptr == AW'(DEPTH - 1));

    // ----------------------------------------------------------------
    // Offset registers
    // ----------------------------------------------------------------
    // Distance pair with its own load and readback sequences.
    sfq_offset_pair #(
        .OW(OW)
    ) u_offsets (
        .clock(clock),
        .resetn(resetn),
        .clear(rst_cycle),
        .wr_strobe(off_wr),
        .rd_strobe(off_rd_go),
        .wr_data(link.data_in[OW-1:0]),
        .almost_empty_distance(ae_dist),
        .almost_full_distance(af_dist),
        .rd_data(off_rd)
    );

    // ----------------------------------------------------------------
    // Word count and flag decode
    // ----------------------------------------------------------------
    // After a rewind the count is the write pointer's distance from
    // location zero; a full wrap counts as the whole depth.
    wire [CW-1:0] rt_count = (wptr == '0 && wrapped) ? CW'(DEPTH) : CW'(wptr);

    // Count follows the pointers; reset empties, rewind recomputes.
    always_comb begin
        if (rst_cycle) begin
            next_count = '0;
        end else if (rt_go) begin
            next_count = rt_count;
        end else begin
            next_count = count + CW'(wr_fifo) - CW'(rd_fifo);
        end
    end

    // Flag thresholds on the count after this edge.
    wire [XW-1:0] nc = XW'(next_count);
    wire [XW-1:0] dep = XW'(DEPTH);
    wire next_full_n = nc != dep;
    wire next_empty_n = nc != '0;
    wire next_ae_n = nc > XW'(ae_dist);
    wire next_af_n = nc < (dep - XW'(af_dist));
    wire next_hf_n = !(nc > (dep >> 1));
    // Chain pulses low for one cycle when the last location is used.
    wire next_wxo_n = !(link.depth_mode && wr_last);
    wire next_rxo_n = !(link.depth_mode && rd_last);
    // The half-full pin is handed over to the write chain in a cascade.
    wire next_hf_pin = link.depth_mode ? next_wxo_n : next_hf_n;

    // ----------------------------------------------------------------
    // Pointers, count and flag registers
    // ----------------------------------------------------------------
    // All flags update only on the clock; both sync settings agree
    // because both sides share this one clock.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wptr <= '0;
            rptr <= '0;
            wrapped <= 1'b0;
            count <= '0;
            link.full_flag_n <= 1'b1;
            link.empty_flag_n <= 1'b0;
            link.almost_empty_flag_n <= 1'b0;
            link.almost_full_flag_n <= 1'b1;
            link.half_full_flag_n <= 1'b1;
            link.read_chain_out_n <= 1'b1;
        end else begin
            count <= next_count;
            link.full_flag_n <= next_full_n;
            link.empty_flag_n <= next_empty_n;
            link.almost_empty_flag_n <= next_ae_n;
            link.almost_full_flag_n <= next_af_n;
            link.half_full_flag_n <= next_hf_pin;
            link.read_chain_out_n <= next_rxo_n;
            if (rst_cycle) begin
                wptr <= '0;
                rptr <= '0;
                wrapped <= 1'b0;
            end else begin
                if (wr_fifo) begin
                    wptr <= wptr + 1'b1;
                end
                if (wr_last) begin
                    wrapped <= 1'b1;
                end
                if (rt_go) begin
                    rptr <= '0;
                end else if (rd_fifo) begin
                    rptr <= rptr + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Cascade tokens
    // ----------------------------------------------------------------
    // The strap is caught during a reset cycle, never at async reset.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wtoken <= 1'b0;
            rtoken <= 1'b0;
        end else if (rst_cycle) begin
            wtoken <= !link.first_device_strap_n;
            rtoken <= !link.first_device_strap_n;
        end else begin
            if (!link.write_chain_in_n) begin
                wtoken <= 1'b1;
            end else if (wr_last && link.depth_mode) begin
                wtoken <= 1'b0;
            end
            if (!link.read_chain_in_n) begin
                rtoken <= 1'b1;
            end else if (rd_last && link.depth_mode) begin
                rtoken <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data path
    // ----------------------------------------------------------------
    // Array write; no reset on storage.
    always_ff @(posedge clock) begin
        if (wr_fifo) begin
            mem[wptr] <= link.data_in;
        end
    end

    // Output word: FIFO data, offset readback, or low after reset.
    // An empty FIFO keeps the last word read.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link.data_out <= '0;
        end else if (rst_cycle) begin
            link.data_out <= '0;
        end else if (off_rd_go) begin
            link.data_out <= {{(DW - OW){1'b0}}, off_rd};
        end else if (rd_fifo) begin
            link.data_out <= mem[rptr];
        end
    end
endmodule
`default_nettype wire

// ===== core/sfq_regs.svh
// Constants shared by the FIFO device end and its controller end.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SFQ_REGS_SVH
`define SFQ_REGS_SVH
`define SFQ_DATA_W 18
`define SFQ_OFFSET_W 14
`define SFQ_DEPTH_SMALL 8192
`define SFQ_DEPTH_LARGE 16384
`define SFQ_OFFSET_DEFAULT 14'h007f
`define SFQ_CLK_NS 4
`define SFQ_RTR_NS 12
`define SFQ_RTR_CYC ((`SFQ_RTR_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS)
`define SFQ_REG_WRITE 8'h00
`define SFQ_REG_READ 8'h04
`define SFQ_REG_RDATA 8'h08
`define SFQ_REG_STATUS 8'h0c
`define SFQ_REG_CONFIG 8'h10
`define SFQ_REG_CTRL 8'h14
`define SFQ_CMD_OFFSET_BIT 18
`define SFQ_CTRL_RESET_BIT 0
`define SFQ_CTRL_RT_BIT 1
`define SFQ_CFG_SYNC_BIT 0
`define SFQ_CFG_DEPTH_BIT 1
`define SFQ_CFG_STRAP_BIT 2
`endif

// ===== core/sfq_pkg.sv
// Types shared by the FIFO ends.
// Assumes nothing beyond a SystemVerilog compiler.
package sfq_pkg;
    // Controller command state, one-hot.
    typedef enum logic [1:0] {
        SFQ_ST_IDLE = 2'b01,
        SFQ_ST_RECOVER = 2'b10
    } sfq_ctrl_state_t;
endpackage

// ===== core/sfq_link_if.sv
// Pin-level link between the FIFO device and its controlling logic.
// Assumes both ends run on one common clock.
`timescale 1ns/10ps
`default_nettype none
`include "sfq_regs.svh"
interface sfq_link_if;
    logic [`SFQ_DATA_W-1:0] data_in;
    logic [`SFQ_DATA_W-1:0] data_out;
    logic wen_n;
    logic ren_n;
    logic offset_load_select_n;
    logic retransmit_pulse;
    logic master_reset_n;
    logic flag_sync_select;
    logic depth_mode;
    logic first_device_strap_n;
    logic write_chain_in_n;
    logic read_chain_in_n;
    logic read_chain_out_n;
    logic full_flag_n;
    logic empty_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic half_full_flag_n;
    modport dev (
        input data_in, wen_n, ren_n, offset_load_select_n, retransmit_pulse,
        input master_reset_n, flag_sync_select, depth_mode, first_device_strap_n,
        input write_chain_in_n, read_chain_in_n,
        output data_out, read_chain_out_n, full_flag_n, empty_flag_n,
        output almost_empty_flag_n, almost_full_flag_n, half_full_flag_n
    );
    modport ctrl (
        output data_in, wen_n, ren_n, offset_load_select_n, retransmit_pulse,
        output master_reset_n, flag_sync_select, depth_mode, first_device_strap_n,
        output write_chain_in_n, read_chain_in_n,
        input data_out, read_chain_out_n, full_flag_n, empty_flag_n,
        input almost_empty_flag_n, almost_full_flag_n, half_full_flag_n
    );
endinterface
`default_nettype wire

// ===== core/sfq_offset_pair.sv
// Pair of almost-empty / almost-full distance registers with their
// alternating selection sequence for loads and for readback.
// Assumes strobes are already qualified by the offset load select.
`timescale 1ns/10ps
`default_nettype none
`include "sfq_regs.svh"
module sfq_offset_pair #(
    parameter int OW = `SFQ_OFFSET_W
) (
    input wire logic clock, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic clear, // Reset cycle: defaults and sequence restart.
    input wire logic wr_strobe, // Load the selected register.
    input wire logic rd_strobe, // Read back the selected register.
    input wire logic [OW-1:0] wr_data, // Load value.
    output logic [OW-1:0] almost_empty_distance, // Almost-empty distance.
    output logic [OW-1:0] almost_full_distance, // Almost-full distance.
    output logic [OW-1:0] rd_data // Register picked for readback.
);
    logic wr_sel;
    logic rd_sel;

    // Readback picks empty first, then full.
    assign rd_data = rd_sel ? almost_full_distance : almost_empty_distance;

    // Load sequence: empty, full, empty again, each on one strobe.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            almost_empty_distance <= `SFQ_OFFSET_DEFAULT;
            almost_full_distance <= `SFQ_OFFSET_DEFAULT;
            wr_sel <= 1'b0;
            rd_sel <= 1'b0;
        end else if (clear) begin
            almost_empty_distance <= `SFQ_OFFSET_DEFAULT;
            almost_full_distance <= `SFQ_OFFSET_DEFAULT;
            wr_sel <= 1'b0;
            rd_sel <= 1'b0;
        end else begin
            if (wr_strobe && !wr_sel) begin
                almost_empty_distance <= wr_data;
            end
            if (wr_strobe && wr_sel) begin
                almost_full_distance <= wr_data;
            end
            if (wr_strobe) begin
                wr_sel <= !wr_sel;
            end
            if (rd_strobe) begin
                rd_sel <= !rd_sel;
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/sfq_ctrl.sv
// Controller end: AHB-Lite register slave that turns software orders
// into FIFO write, read, reset and retransmit strobes.
// Assumes one FIFO device on the link, cascaded onto itself when the
// depth-expansion setting is chosen.
`timescale 1ns/10ps
`default_nettype none
`include "sfq_regs.svh"
module sfq_ctrl
    import sfq_pkg::*;
#(
    parameter int RTR_CYC = `SFQ_RTR_CYC
) (
    input wire logic clock, // Common clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size, word only.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    sfq_link_if.ctrl link // Pins toward the device.
);
    sfq_ctrl_state_t state;
    logic [7:0] a_addr;
    logic a_write;
    logic [7:0] rtr_cnt;
    logic rd_pending;
    logic [`SFQ_DATA_W-1:0] rdata;
    logic [31:0] rd_mux;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire take = hsel && htrans[1] && hready;
    wire idle = state == SFQ_ST_IDLE;
    wire wr_cmd = a_write && a_addr == `SFQ_REG_WRITE && idle;
    wire rd_cmd = a_write && a_addr == `SFQ_REG_READ && idle;
    wire wr_cfg = a_write && a_addr == `SFQ_REG_CONFIG;
    wire wr_ctl = a_write && a_addr == `SFQ_REG_CTRL;
    wire do_rst = wr_ctl && hwdata[`SFQ_CTRL_RESET_BIT];
    // Retransmit is refused until the previous recovery has run out.
    wire do_rt = wr_ctl && hwdata[`SFQ_CTRL_RT_BIT] && idle;
    wire [31:0] status = {25'h0000000, !idle, link.read_chain_out_n,
        link.full_flag_n, link.almost_full_flag_n, link.half_full_flag_n,
        link.almost_empty_flag_n, link.empty_flag_n};
    wire [31:0] config_word = {29'h00000000, link.first_device_strap_n,
        link.depth_mode, link.flag_sync_select};

    // Read data selection; unmapped words read as zero.
    always_comb begin
        case (haddr[7:0])
            `SFQ_REG_RDATA: rd_mux = {14'h0000, rdata};
            `SFQ_REG_STATUS: rd_mux = status;
            `SFQ_REG_CONFIG: rd_mux = config_word;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus slave: zero wait states, address latched for the data phase
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            a_addr <= 8'h00;
            a_write <= 1'b0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            a_addr <= haddr[7:0];
            a_write <= take && hwrite;
            hrdata <= (take && !hwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Link strobes: one-cycle pulses, active-low levels idle high, retransmit idles low
    // ----------------------------------------------------------------
    // Reset value low gives the device a reset cycle after power-up.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link.wen_n <= 1'b1;
            link.ren_n <= 1'b1;
            link.offset_load_select_n <= 1'b1;
            link.data_in <= '0;
            link.master_reset_n <= 1'b0;
            link.retransmit_pulse <= 1'b0;
        end else begin
            link.wen_n <= !wr_cmd;
            link.ren_n <= !rd_cmd;
            link.offset_load_select_n <= !((wr_cmd || rd_cmd) && hwdata[`SFQ_CMD_OFFSET_BIT]);
            if (wr_cmd) begin
                link.data_in <= hwdata[`SFQ_DATA_W-1:0];
            end
            link.master_reset_n <= !do_rst;
            link.retransmit_pulse <= do_rt;
        end
    end

    // ----------------------------------------------------------------
    // Configuration and cascade loopback
    // ----------------------------------------------------------------
    // A lone device in depth mode closes its chain onto itself.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link.flag_sync_select <= 1'b0;
            link.depth_mode <= 1'b0;
            link.first_device_strap_n <= 1'b0;
            link.write_chain_in_n <= 1'b1;
            link.read_chain_in_n <= 1'b1;
        end else begin
            if (wr_cfg) begin
                link.flag_sync_select <= hwdata[`SFQ_CFG_SYNC_BIT];
                link.depth_mode <= hwdata[`SFQ_CFG_DEPTH_BIT];
                link.first_device_strap_n <= hwdata[`SFQ_CFG_STRAP_BIT];
            end
            link.write_chain_in_n <= !link.depth_mode || link.half_full_flag_n;
            link.read_chain_in_n <= !link.depth_mode || link.read_chain_out_n;
        end
    end

    // ----------------------------------------------------------------
    // Retransmit recovery and read capture
    // ----------------------------------------------------------------
    // Write, read and rewind strobes stay off from the pulse until the recovery count ends; reset is not held.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= SFQ_ST_IDLE;
            rtr_cnt <= 8'h00;
            rd_pending <= 1'b0;
            rdata <= '0;
        end else begin
            rd_pending <= !link.ren_n;
            if (rd_pending) begin
                rdata <= link.data_out;
            end
            case (state)
                SFQ_ST_IDLE: begin
                    if (do_rt) begin
                        state <= SFQ_ST_RECOVER;
                        rtr_cnt <= 8'(RTR_CYC);
                    end
                end
                SFQ_ST_RECOVER: begin
                    rtr_cnt <= rtr_cnt - 8'h01;
                    if (rtr_cnt == 8'h00) begin
                        state <= SFQ_ST_IDLE;
                    end
                end
                default: begin
                    state <= SFQ_ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/sfq_link_properties.sv
// Concurrent checks on the link between the FIFO device and its controller.
// Assumes one common clock; link signals arrive as plain inputs.
`timescale 1ns/10ps
`default_nettype none
`include "sfq_regs.svh"
module sfq_link_properties (
    input wire logic clock, // Clock.
    input wire logic resetn, // Reset, active low.
    input wire logic [`SFQ_DATA_W-1:0] data_out, // Read data.
    input wire logic wen_n, // Write strobe.
    input wire logic ren_n, // Read strobe.
    input wire logic offset_load_select_n, // Offset access.
    input wire logic retransmit_pulse, // Rewind.
    input wire logic master_reset_n, // Reset cycle.
    input wire logic depth_mode, // Cascade mode.
    input wire logic full_flag_n, // Full.
    input wire logic empty_flag_n, // Empty.
    input wire logic almost_empty_flag_n, // Almost empty.
    input wire logic half_full_flag_n // Half full.
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // An edge with no reset cycle and no rewind, then plain FIFO strobes.
    sequence s_quiet;
        master_reset_n && !retransmit_pulse;
    endsequence
    sequence s_fifo;
        s_quiet ##0 offset_load_select_n;
    endsequence
    property p_full_hold;
        s_fifo ##0 (!full_flag_n && !wen_n && ren_n) |=> !full_flag_n;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("write taken while full");
    property p_empty_hold;
        s_fifo ##0 (!empty_flag_n && !ren_n && wen_n) |=> !empty_flag_n && $stable(data_out);
    endproperty
    a_empty_hold: assert property (p_empty_hold)
        else $error("read taken while empty");
    property p_reset_cycle;
        !master_reset_n |=> !empty_flag_n && full_flag_n && !almost_empty_flag_n && data_out == '0;
    endproperty
    a_reset_cycle: assert property (p_reset_cycle)
        else $error("reset cycle left the fifo not empty");
    property p_offset_count;
        s_quiet ##0 (!offset_load_select_n && !wen_n && ren_n && !depth_mode)
            |=> $stable({empty_flag_n, full_flag_n, half_full_flag_n});
    endproperty
    a_offset_count: assert property (p_offset_count)
        else $error("offset load moved the word count");
    property p_fill_empty;
        s_fifo ##0 (!empty_flag_n && !wen_n && ren_n && !depth_mode) |=> empty_flag_n;
    endproperty
    a_fill_empty: assert property (p_fill_empty)
        else $error("write into empty fifo left empty flag low");
    property p_rt_depth;
        retransmit_pulse && depth_mode && master_reset_n && wen_n && ren_n
            |=> $stable({empty_flag_n, full_flag_n});
    endproperty
    a_rt_depth: assert property (p_rt_depth)
        else $error("rewind acted in cascade mode");
    property p_full_cause;
        $fell(full_flag_n) |-> $past(!wen_n || retransmit_pulse);
    endproperty
    a_full_cause: assert property (p_full_cause)
        else $error("full flag fell without a write");
    property p_empty_cause;
        $fell(empty_flag_n) |-> $past(!ren_n || !master_reset_n || retransmit_pulse);
    endproperty
    a_empty_cause: assert property (p_empty_cause)
        else $error("empty flag fell without a read");
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: AHB-Lite master driving the controller and device.
// Assumes a shallow device depth so that full and half-full are reached.
`timescale 1ns/10ps
`default_nettype none
`include "sfq_regs.svh"
module testbench;
    localparam int D = 256;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    sfq_link_if link();
    sfq_fifo_dev #(.DEPTH(D)) i_sfq_fifo_dev (.clock(clock), .resetn(resetn), .link(link));
    sfq_ctrl #(.RTR_CYC(3)) i_sfq_ctrl (.clock(clock), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
    sfq_link_properties i_sfq_link_properties (.clock(clock), .resetn(resetn),
        .data_out(link.data_out), .wen_n(link.wen_n), .ren_n(link.ren_n),
        .offset_load_select_n(link.offset_load_select_n),
        .retransmit_pulse(link.retransmit_pulse), .master_reset_n(link.master_reset_n),
        .depth_mode(link.depth_mode), .full_flag_n(link.full_flag_n),
        .empty_flag_n(link.empty_flag_n), .almost_empty_flag_n(link.almost_empty_flag_n),
        .half_full_flag_n(link.half_full_flag_n));
    // Clock and a cycle ceiling that cuts a hang short.
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            print_verdict();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single transfer, then two idle cycles so strobes and flags land.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
        repeat (2) @(posedge clock);
    endtask
    task automatic put(input logic [31:0] v);
        ahb(1'b1, `SFQ_REG_WRITE, v);
    endtask
    // Read a FIFO word or an offset register and compare the captured word.
    task automatic get(input logic off, input logic [31:0] exp);
        ahb(1'b1, `SFQ_REG_READ, {13'h0, off, 18'h0});
        ahb(1'b0, `SFQ_REG_RDATA, 32'h0);
        check(rd, exp);
    endtask
    task automatic status(input logic [31:0] exp);
        ahb(1'b0, `SFQ_REG_STATUS, 32'h0);
        check(rd, exp);
    endtask
    // Poll until the rewind recovery time is over.
    task automatic settle;
        do ahb(1'b0, `SFQ_REG_STATUS, 32'h0); while (rd[6] === 1'b1);
    endtask
    function automatic logic [31:0] st(int n, int ae, int af);
        return {25'h0, 2'b01, 1'(n != D), 1'(n < D - af), 1'(n <= D / 2), 1'(n > ae), 1'(n != 0)};
    endfunction
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_offsets;
        get(1'b1, 32'h7f);
        get(1'b1, 32'h7f);
        put(32'h40005);
        put(32'h40006);
        put(32'h40003);
        put(32'h40009);
        get(1'b1, 32'h3);
        get(1'b1, 32'h9);
        status(st(0, 3, 9));
        $display("offsets test done");
    endtask
    task automatic t_flags;
        for (int n = 1; n <= D; n++) begin
            put(32'(n));
            status(st(n, 3, 9));
        end
        put(32'h3ffff);
        status(st(D, 3, 9));
        for (int n = 1; n <= D; n++) begin
            get(1'b0, 32'(n));
            status(st(D - n, 3, 9));
        end
        get(1'b0, 32'(D));
        $display("flags test done");
    endtask
    // Both selection sequences are left mid-way so that a missed restart shows.
    task automatic t_retransmit;
        put(32'h40011);
        get(1'b1, 32'h11);
        ahb(1'b1, `SFQ_REG_CTRL, 32'h1);
        status(st(0, 127, 127));
        put(32'h40005);
        get(1'b1, 32'h5);
        get(1'b1, 32'h7f);
        for (int n = 1; n <= 4; n++) put(32'h100 + 32'(n));
        get(1'b0, 32'h101);
        get(1'b0, 32'h102);
        ahb(1'b1, `SFQ_REG_CTRL, 32'h2);
        settle();
        status(st(4, 5, 127));
        for (int n = 1; n <= 4; n++) get(1'b0, 32'h100 + 32'(n));
        put(32'h1ff);
        get(1'b0, 32'h1ff);
        $display("retransmit test done");
    endtask
    task automatic t_depth;
        ahb(1'b1, `SFQ_REG_CONFIG, 32'h3);
        ahb(1'b0, `SFQ_REG_CONFIG, 32'h0);
        check(rd, 32'h3);
        ahb(1'b0, 8'h1c, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, `SFQ_REG_CTRL, 32'h1);
        put(32'h201);
        put(32'h202);
        get(1'b0, 32'h201);
        ahb(1'b1, `SFQ_REG_CTRL, 32'h2);
        settle();
        get(1'b0, 32'h202);
        // Past half the depth the shared pin still carries the chain.
        for (int n = 0; n <= D / 2; n++) put(32'(n));
        status(st(D / 2 + 1, 127, 127) | 32'h4);
        // A strap-high device holds no token and takes no write.
        ahb(1'b1, `SFQ_REG_CONFIG, 32'h7);
        ahb(1'b1, `SFQ_REG_CTRL, 32'h1);
        put(32'h203);
        status(st(0, 127, 127));
        $display("depth test done");
    endtask
    // Reset, then the scenarios in order.
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        t_offsets();
        t_flags();
        t_retransmit();
        t_depth();
        print_verdict();
    end
endmodule
`default_nettype wire
